// File: rtl/tmr16_ctrl.v
// Purpose: Control registers, prescaler, counter and waveform logic of a 16-bit timer
// Assumes: AXI4-Lite slave on mclk, synchronous active-high reset
// Notes:   Notes on behaviour follow
// Notes on behaviour
// - standby_run one keeps the timer counting during Standby sleep; zero halts it.
// - prescale_select picks count clock divide of 1,2,4,8,16,64,256,1024.
// - Enable bit, bit 0 of main control, switches the timer off or on.
// - In waveform modes a compare output enable drives the channel onto its pin.
// - Auto-lock holds lock update until every enabled compare buffer is valid.
// - After auto-lock clears the lock, next UPDATE transfers buffers and relocks.
// - Without auto-lock, hardware never touches the lock update bit.
// - waveform_mode picks normal, frequency, single-slope or dual-slope; 2 and 4 reserved.
// - UPDATE and overflow points depend on the waveform mode as tabled.
// - Normal mode makes no waveform; others reach pins only when enabled.
// - While disabled, compare output value writes set waveform outputs directly.
// - Overrides reach a pad only when enabled; logic block output bypasses enable.
// - split_enable turns the timer into two independent 8-bit counters.
// - Writing one into a clear register clears that control bit.
// - Writing one into the set register sets that control bit.
// - Command 1 forces update, 2 restarts, 3 hard resets unless enabled.
// - The command field always reads as zero.
// - Lock clear lets UPDATE load buffers; lock set blocks that load.
// - A forced update transfers buffers even while locked.
// - Direction zero counts up, one counts down; hardware and software change it.
// - Compare buffer valid sets on buffer write, clears on update.
// - Period buffer valid sets on buffer write, clears on update.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
`include "tmr16_consts.vh"

module tmr16_ctrl
(
    // Clock and reset
    input  wire        mclk,
    input  wire        sys_rst,
    // AXI4-Lite write address and data
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [9:0]  s_axi_awaddr,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    output reg  [1:0]  s_axi_bresp,
    // AXI4-Lite read
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [9:0]  s_axi_araddr,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    // System state
    input  wire        standby_sleep,
    // Waveform and event outputs
    output reg  [2:0]  waveform_output_pad,
    output reg  [2:0]  waveform_output_pad_oe,
    output reg  [2:0]  waveform_output_clb,
    output reg         overflow_event,
    output reg         update_event
);

////////////////////////////////////////////////////////////////////////////////
// Register state

reg        enable_reg;
reg        standby_run_reg;
reg [2:0]  prescale_select_reg;
reg [2:0]  compare_output_enable_reg;
reg        auto_lock_update_reg;
reg [2:0]  waveform_mode_reg;
reg [2:0]  compare_output_value_reg;
reg        split_enable_reg;
reg        lock_update_reg;
reg        dir_reg;
reg [2:0]  compare_buffer_valid_reg;
reg        period_buffer_valid_reg;
reg [15:0] cnt_reg;
reg [15:0] per_reg;
reg [15:0] per_buf_reg;
reg [15:0] cmp_reg [0:2];
reg [15:0] compare_buffer_reg [0:2];
reg [9:0]  pre_reg;
reg [2:0]  wg_reg;
reg        stby_s1_reg;
reg        stby_s2_reg;

// Bus state
reg        aw_have_reg;
reg        w_have_reg;
reg [7:0]  waddr_reg;
reg [31:0] wdata_reg;
reg [3:0]  wstrb_reg;

integer i;

////////////////////////////////////////////////////////////////////////////////
// Bus handshakes

assign s_axi_awready = ~aw_have_reg & ~s_axi_bvalid;
assign s_axi_wready  = ~w_have_reg & ~s_axi_bvalid;
assign s_axi_arready = ~s_axi_rvalid;

wire       wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
wire       wlo     = wr_fire & wstrb_reg[0];
wire       whi     = wr_fire & wstrb_reg[1];
wire [7:0] wb      = wdata_reg[7:0];

// Write hits per register
wire hit_main   = wlo & (waddr_reg == `TMR16_IDX_MAIN);
wire hit_wave   = wlo & (waddr_reg == `TMR16_IDX_WAVE);
wire hit_ovr    = wlo & (waddr_reg == `TMR16_IDX_OVR);
wire hit_split  = wlo & (waddr_reg == `TMR16_IDX_SPLIT);
wire hit_eclr   = wlo & (waddr_reg == `TMR16_IDX_ECLR);
wire hit_eset   = wlo & (waddr_reg == `TMR16_IDX_ESET);
wire hit_fclr   = wlo & (waddr_reg == `TMR16_IDX_FCLR);
wire hit_fset   = wlo & (waddr_reg == `TMR16_IDX_FSET);
wire hit_perbuf = wr_fire & (waddr_reg == `TMR16_IDX_PERBUF);
wire [2:0] hit_cmpbuf;
assign hit_cmpbuf[0] = wr_fire & (waddr_reg == `TMR16_IDX_CMP0BUF);
assign hit_cmpbuf[1] = wr_fire & (waddr_reg == `TMR16_IDX_CMP1BUF);
assign hit_cmpbuf[2] = wr_fire & (waddr_reg == `TMR16_IDX_CMP2BUF);

// Command decode from either half of the set/clear pair
wire [1:0] cmd = (hit_eclr | hit_eset) ? wb[`TMR16_B_CMD+1:`TMR16_B_CMD] : `TMR16_CMD_NONE;
wire force_upd = (cmd == `TMR16_CMD_UPDATE);
wire force_rst = (cmd == `TMR16_CMD_RESTART);
wire hard_rst  = (cmd == `TMR16_CMD_HARDRST) & ~enable_reg;

////////////////////////////////////////////////////////////////////////////////
// Prescaler and count tick

reg [9:0] pre_mask;
always @*
begin
    case (prescale_select_reg)
        3'h0:    pre_mask = 10'h000;
        3'h1:    pre_mask = 10'h001;
        3'h2:    pre_mask = 10'h003;
        3'h3:    pre_mask = 10'h007;
        3'h4:    pre_mask = 10'h00F;
        3'h5:    pre_mask = 10'h03F;
        3'h6:    pre_mask = 10'h0FF;
        default: pre_mask = 10'h3FF;
    endcase
end

wire run  = enable_reg & (standby_run_reg | ~stby_s2_reg);
wire tick = run & ((pre_reg & pre_mask) == pre_mask);

////////////////////////////////////////////////////////////////////////////////
// Counting events

wire        dual   = (waveform_mode_reg == `TMR16_WG_DS_TOP) | (waveform_mode_reg == `TMR16_WG_DS_BOTH) |
                     (waveform_mode_reg == `TMR16_WG_DS_BOT);
wire [15:0] top    = (waveform_mode_reg == `TMR16_WG_FREQ) ? cmp_reg[0] : per_reg;
wire        at_top = tick & ~dir_reg & (cnt_reg == top);
wire        at_bot = tick & dir_reg & (cnt_reg == `TMR16_RST_WORD);
wire        lo_unf = tick & (cnt_reg[7:0] == 8'h00);
wire        hi_unf = tick & (cnt_reg[15:8] == 8'h00);

// UPDATE and overflow points per mode
reg upd_cond;
reg ovf_cond;
always @*
begin
    upd_cond = 1'b0;
    ovf_cond = 1'b0;
    if (split_enable_reg)
    begin
        ovf_cond = lo_unf;
    end
    else
    begin
        case (waveform_mode_reg)
            `TMR16_WG_NORMAL, `TMR16_WG_FREQ, `TMR16_WG_SINGLE:
            begin
                upd_cond = at_top | at_bot;
                ovf_cond = at_top | at_bot;
            end
            `TMR16_WG_DS_TOP:
            begin
                upd_cond = at_bot;
                ovf_cond = at_top;
            end
            `TMR16_WG_DS_BOTH:
            begin
                upd_cond = at_bot;
                ovf_cond = at_top | at_bot;
            end
            `TMR16_WG_DS_BOT:
            begin
                upd_cond = at_bot;
                ovf_cond = at_bot;
            end
            default:
            begin
                upd_cond = 1'b0;
                ovf_cond = 1'b0;
            end
        endcase
    end
end

wire xfer     = (upd_cond & ~lock_update_reg) | force_upd;
wire all_bv   = &(compare_buffer_valid_reg | ~compare_output_enable_reg);
wire wg_pins  = (waveform_mode_reg != `TMR16_WG_NORMAL) & ~split_enable_reg;

////////////////////////////////////////////////////////////////////////////////
// Synchroniser for the standby sleep level

always @(posedge mclk)
begin
    if (sys_rst)
    begin
        stby_s1_reg <= 1'b0;
        stby_s2_reg <= 1'b0;
    end
    else
    begin
        stby_s1_reg <= standby_sleep;
        stby_s2_reg <= stby_s1_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Timer core and control registers

always @(posedge mclk)
begin
    if (sys_rst | hard_rst)
    begin
        enable_reg                <= 1'b0;
        standby_run_reg           <= 1'b0;
        prescale_select_reg       <= 3'h0;
        compare_output_enable_reg <= 3'h0;
        auto_lock_update_reg      <= 1'b0;
        waveform_mode_reg         <= `TMR16_WG_NORMAL;
        compare_output_value_reg  <= 3'h0;
        split_enable_reg          <= 1'b0;
        lock_update_reg           <= 1'b0;
        dir_reg                   <= 1'b0;
        compare_buffer_valid_reg  <= 3'h0;
        period_buffer_valid_reg   <= 1'b0;
        cnt_reg                   <= `TMR16_RST_WORD;
        per_reg                   <= `TMR16_RST_PER;
        per_buf_reg               <= `TMR16_RST_PER;
        pre_reg                   <= 10'h000;
        wg_reg                    <= 3'h0;
        overflow_event            <= 1'b0;
        update_event              <= 1'b0;
        for (i = 0; i < 3; i = i + 1)
        begin
            cmp_reg[i]            <= `TMR16_RST_WORD;
            compare_buffer_reg[i] <= `TMR16_RST_WORD;
        end
    end
    else
    begin
        overflow_event <= ovf_cond;
        update_event   <= upd_cond;
        // Prescaler runs only while counting is allowed
        if (run)
            pre_reg <= pre_reg + 10'h001;
        // Counter stepping
        if (tick & split_enable_reg)
        begin
            // Two 8-bit down counters reloading from the period bytes
            cnt_reg[7:0]  <= lo_unf ? per_reg[7:0] : cnt_reg[7:0] - 8'h01;
            cnt_reg[15:8] <= hi_unf ? per_reg[15:8] : cnt_reg[15:8] - 8'h01;
        end
        else if (tick & dual)
        begin
            if (at_top)
            begin
                dir_reg <= 1'b1;
                cnt_reg <= cnt_reg - 16'h0001;
            end
            else if (at_bot)
            begin
                dir_reg <= 1'b0;
                cnt_reg <= cnt_reg + 16'h0001;
            end
            else
                cnt_reg <= dir_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
        end
        else if (tick)
        begin
            if (at_top)
                cnt_reg <= `TMR16_RST_WORD;
            else if (at_bot)
                cnt_reg <= top;
            else
                cnt_reg <= dir_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
        end
        // Waveform generator
        if (~enable_reg & hit_ovr)
            wg_reg <= wb[2:0];
        else if (tick & wg_pins)
        begin
            if (waveform_mode_reg == `TMR16_WG_FREQ)
                wg_reg[0] <= wg_reg[0] ^ at_top;
            else
                for (i = 0; i < 3; i = i + 1)
                    wg_reg[i] <= (cnt_reg < cmp_reg[i]);
        end
        // Buffer transfer on UPDATE or forced update
        if (xfer)
        begin
            if (period_buffer_valid_reg)
                per_reg <= per_buf_reg;
            period_buffer_valid_reg <= 1'b0;
            for (i = 0; i < 3; i = i + 1)
                if (compare_buffer_valid_reg[i])
                    cmp_reg[i] <= compare_buffer_reg[i];
            compare_buffer_valid_reg <= 3'h0;
        end
        // Auto-lock sequencing of the lock bit
        // Without auto-lock only software writes move the lock bit
        if (auto_lock_update_reg)
        begin
            if (upd_cond & ~lock_update_reg)
                lock_update_reg <= 1'b1;
            else if (lock_update_reg & all_bv)
                lock_update_reg <= 1'b0;
        end
        // Forced restart keeps configuration
        if (force_rst)
        begin
            cnt_reg <= `TMR16_RST_WORD;
            dir_reg <= 1'b0;
            pre_reg <= 10'h000;
        end
        // Plain control writes
        if (hit_main)
        begin
            standby_run_reg     <= wb[`TMR16_B_STBY];
            prescale_select_reg <= wb[3:1];
            enable_reg          <= wb[`TMR16_B_ENABLE];
        end
        if (hit_wave)
        begin
            compare_output_enable_reg <= wb[6:4];
            auto_lock_update_reg      <= wb[`TMR16_B_AUTO_LOCK_UPDATE];
            waveform_mode_reg         <= wb[2:0];
            if (wb[`TMR16_B_AUTO_LOCK_UPDATE])
                lock_update_reg <= 1'b1;
        end
        if (hit_ovr)
            compare_output_value_reg <= wb[2:0];
        if (hit_split)
            split_enable_reg <= wb[0];
        // Set and clear pairs, zero bits leave state alone
        if (hit_eclr)
        begin
            if (wb[`TMR16_B_LOCK])
                lock_update_reg <= 1'b0;
            if (wb[`TMR16_B_DIR])
                dir_reg <= 1'b0;
        end
        if (hit_eset)
        begin
            if (wb[`TMR16_B_LOCK])
                lock_update_reg <= 1'b1;
            if (wb[`TMR16_B_DIR])
                dir_reg <= 1'b1;
        end
        if (hit_fclr)
        begin
            compare_buffer_valid_reg <= compare_buffer_valid_reg & ~wb[3:1];
            period_buffer_valid_reg  <= period_buffer_valid_reg & ~wb[0];
        end
        if (hit_fset)
        begin
            compare_buffer_valid_reg <= compare_buffer_valid_reg | wb[3:1];
            period_buffer_valid_reg  <= period_buffer_valid_reg | wb[0];
        end
        // Buffer writes set their valid flag and win over a same-cycle clear
        if (hit_perbuf)
        begin
            if (wstrb_reg[0])
                per_buf_reg[7:0] <= wb;
            if (wstrb_reg[1])
                per_buf_reg[15:8] <= wdata_reg[15:8];
            period_buffer_valid_reg <= 1'b1;
        end
        for (i = 0; i < 3; i = i + 1)
            if (hit_cmpbuf[i])
            begin
                if (wstrb_reg[0])
                    compare_buffer_reg[i][7:0] <= wb;
                if (wstrb_reg[1])
                    compare_buffer_reg[i][15:8] <= wdata_reg[15:8];
                compare_buffer_valid_reg[i] <= 1'b1;
            end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Output routing

always @(posedge mclk)
begin
    if (sys_rst)
    begin
        waveform_output_pad    <= 3'h0;
        waveform_output_pad_oe <= 3'h0;
        waveform_output_clb    <= 3'h0;
    end
    else
    begin
        waveform_output_pad    <= wg_reg & compare_output_enable_reg;
        waveform_output_pad_oe <= compare_output_enable_reg;
        waveform_output_clb    <= wg_reg;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data selection

reg [15:0] rd_val;
reg        rd_ok;
always @*
begin
    rd_ok  = 1'b1;
    rd_val = `TMR16_RST_WORD;
    case (s_axi_araddr[9:2])
        `TMR16_IDX_MAIN:    rd_val = {8'h00, standby_run_reg, 3'h0, prescale_select_reg, enable_reg};
        `TMR16_IDX_WAVE:    rd_val = {8'h00, 1'b0, compare_output_enable_reg, auto_lock_update_reg,
                                      waveform_mode_reg};
        `TMR16_IDX_OVR:     rd_val = {13'h0000, compare_output_value_reg};
        `TMR16_IDX_SPLIT:   rd_val = {15'h0000, split_enable_reg};
        `TMR16_IDX_ECLR,
        `TMR16_IDX_ESET:    rd_val = {14'h0000, lock_update_reg, dir_reg};
        `TMR16_IDX_FCLR,
        `TMR16_IDX_FSET:    rd_val = {12'h000, compare_buffer_valid_reg, period_buffer_valid_reg};
        `TMR16_IDX_CNT:     rd_val = cnt_reg;
        `TMR16_IDX_PER:     rd_val = per_reg;
        `TMR16_IDX_COMPARE_ZERO_VALUE:    rd_val = cmp_reg[0];
        `TMR16_IDX_CMP1:    rd_val = cmp_reg[1];
        `TMR16_IDX_CMP2:    rd_val = cmp_reg[2];
        `TMR16_IDX_PERBUF:  rd_val = per_buf_reg;
        `TMR16_IDX_CMP0BUF: rd_val = compare_buffer_reg[0];
        `TMR16_IDX_CMP1BUF: rd_val = compare_buffer_reg[1];
        `TMR16_IDX_CMP2BUF: rd_val = compare_buffer_reg[2];
        default:            rd_ok  = 1'b0;
    endcase
end

// Write address of the held request must be mapped to answer OKAY
wire wr_ok = (waddr_reg <= `TMR16_IDX_FSET) | (waddr_reg == `TMR16_IDX_PERBUF) |
             (waddr_reg == `TMR16_IDX_CMP0BUF) | (waddr_reg == `TMR16_IDX_CMP1BUF) |
             (waddr_reg == `TMR16_IDX_CMP2BUF);

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite channel state

always @(posedge mclk)
begin
    if (sys_rst)
    begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        waddr_reg    <= 8'h00;
        wdata_reg    <= 32'h0000_0000;
        wstrb_reg    <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `TMR16_RESP_OKAY;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h0000_0000;
        s_axi_rresp  <= `TMR16_RESP_OKAY;
    end
    else
    begin
        if (s_axi_awvalid & s_axi_awready)
        begin
            aw_have_reg <= 1'b1;
            waddr_reg   <= s_axi_awaddr[9:2];
        end
        if (s_axi_wvalid & s_axi_wready)
        begin
            w_have_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
        end
        if (wr_fire)
        begin
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `TMR16_RESP_OKAY : `TMR16_RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
        if (s_axi_arvalid & s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_val};
            s_axi_rresp  <= rd_ok ? `TMR16_RESP_OKAY : `TMR16_RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

endmodule // tmr16_ctrl

// File: pkg/tmr16_consts.vh
// Purpose: Constants for the 16-bit timer control block
// Assumes: Byte address is four times the register index
// Notes:   Field positions are bit numbers within a register
`ifndef TMR16_CONSTS_VH
`define TMR16_CONSTS_VH

// Register indices as printed
`define TMR16_IDX_MAIN      8'h00
`define TMR16_IDX_WAVE      8'h01
`define TMR16_IDX_OVR       8'h02
`define TMR16_IDX_SPLIT     8'h03
`define TMR16_IDX_ECLR      8'h04
`define TMR16_IDX_ESET      8'h05
`define TMR16_IDX_FCLR      8'h06
`define TMR16_IDX_FSET      8'h07
`define TMR16_IDX_CNT       8'h20
`define TMR16_IDX_PER       8'h26
`define TMR16_IDX_COMPARE_ZERO_VALUE      8'h28
`define TMR16_IDX_CMP1      8'h2A
`define TMR16_IDX_CMP2      8'h2C
`define TMR16_IDX_PERBUF    8'h36
`define TMR16_IDX_CMP0BUF   8'h38
`define TMR16_IDX_CMP1BUF   8'h3A
`define TMR16_IDX_CMP2BUF   8'h3C

// Field positions
`define TMR16_B_ENABLE      0
`define TMR16_B_STBY        7
`define TMR16_B_AUTO_LOCK_UPDATE       3
`define TMR16_B_CMPEN       4
`define TMR16_B_DIR         0
`define TMR16_B_LOCK        1
`define TMR16_B_CMD         2

// Waveform modes
`define TMR16_WG_NORMAL     3'h0
`define TMR16_WG_FREQ       3'h1
`define TMR16_WG_SINGLE     3'h3
`define TMR16_WG_DS_TOP     3'h5
`define TMR16_WG_DS_BOTH    3'h6
`define TMR16_WG_DS_BOT     3'h7

// Commands
`define TMR16_CMD_NONE      2'h0
`define TMR16_CMD_UPDATE    2'h1
`define TMR16_CMD_RESTART   2'h2
`define TMR16_CMD_HARDRST   2'h3

// Reset values
`define TMR16_RST_BYTE      8'h00
`define TMR16_RST_WORD      16'h0000
`define TMR16_RST_PER       16'hFFFF

// Bus answers
`define TMR16_RESP_OKAY     2'h0
`define TMR16_RESP_SLVERR   2'h2

`endif

// File: tb/tmr16_ctrl_properties.sv
// Purpose: Port assertions for the timer control block
// Assumes: One clock mclk, synchronous reset sys_rst
// Notes:   Bound to every tmr16_ctrl instance
`timescale 1ns/1ns
module tmr16_ctrl_props
(
    // Clock and reset
    input wire        mclk,
    input wire        sys_rst,
    // Bus
    input wire        s_axi_awready,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [9:0]  s_axi_araddr,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Waveform
    input wire [2:0]  waveform_output_pad,
    input wire [2:0]  waveform_output_pad_oe,
    input wire [2:0]  waveform_output_clb
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    reg [7:0] rd_idx_reg;
    // Index of the read under way
    always @(posedge mclk)
        if (s_axi_arvalid && s_axi_arready)
            rd_idx_reg <= s_axi_araddr[9:2];
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answer pending");
    write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    write_order_a: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready) && !$past(s_axi_wready))
        else $error("write answer before both channels");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
        else $error("read answer late or wide");
    pad_gate_a: assert property (waveform_output_pad == (waveform_output_clb & waveform_output_pad_oe))
        else $error("pad value not gated by enable");
    cmd_zero_a: assert property (s_axi_rvalid && rd_idx_reg[7:1] == 7'h02 |-> s_axi_rdata[3:2] == 2'h0)
        else $error("command field read nonzero");
endmodule // tmr16_ctrl_props
bind tmr16_ctrl tmr16_ctrl_props props (.*);

// File: tb/test_tmr16_ctrl.sv
// Purpose: Self-checking bench for tmr16_ctrl
// Assumes: Byte address is four times the index
// Notes:   Period forced to 3 keeps counts short
`timescale 1ns/1ns
`include "tmr16_consts.vh"
module test_tmr16_ctrl;
    // Bench inputs and design outputs
    logic        mclk = 0, sys_rst = 1, standby_sleep = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [9:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        overflow_event, update_event;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  waveform_output_pad, waveform_output_pad_oe, waveform_output_clb;
    int          mismatches = 0, n_tests = 0;
    int          dv[8] = '{1, 2, 4, 8, 16, 64, 256, 1024};
    tmr16_ctrl dut (.*);
    // Clock
    always #5 mclk = ~mclk;
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // AXI write, each channel released when taken
    task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic [1:0] er = 2'h0);
        @(posedge mclk);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", er, s_axi_bresp);
    endtask
    // AXI read and compare
    task automatic rd(input string nm, input logic [7:0] i, input logic [15:0] e, input logic [1:0] er = 2'h0);
        @(posedge mclk);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk("rresp", er, s_axi_rresp);
        if (er == 2'h0) chk(nm, e, s_axi_rdata);
    endtask
    // Wait for the next UPDATE pulse
    task automatic wu;
        int k;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (!update_event && k < 8000);
        chk("update seen", 1, update_event);
        chk("overflow seen", 1, overflow_event);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 8; i++) rd("reset value", i, 0);
        rd("period", `TMR16_IDX_PER, `TMR16_RST_PER);
        rd("unmapped", 8'h10, 0, `TMR16_RESP_SLVERR);
        wr(8'h10, 16'h00FF, `TMR16_RESP_SLVERR);
        wr(`TMR16_IDX_ESET, 16'h0003);
        rd("pair view", `TMR16_IDX_ECLR, 16'h0003);
        wr(`TMR16_IDX_ECLR, 16'h0000);
        rd("zero write", `TMR16_IDX_ESET, 16'h0003);
        wr(`TMR16_IDX_ECLR, 16'h0001);
        rd("dir clear", `TMR16_IDX_ESET, 16'h0002);
        wr(`TMR16_IDX_ESET, 16'h0001);
        wr(`TMR16_IDX_ESET, 16'h0008);
        rd("restart", `TMR16_IDX_ESET, 16'h0002);
        wr(`TMR16_IDX_ESET, 16'h000C);
        rd("hard reset", `TMR16_IDX_ESET, 16'h0000);
    endtask
    task automatic t_buf;
        wr(`TMR16_IDX_PERBUF, 16'h0003);
        wr(`TMR16_IDX_CMP0BUF, 16'h0004);
        rd("valid bits", `TMR16_IDX_FSET, 16'h0003);
        wr(`TMR16_IDX_ESET, 16'h0002);
        wr(`TMR16_IDX_ESET, 16'h0004);
        rd("forced copy", `TMR16_IDX_PER, 16'h0003);
        rd("valid clear", `TMR16_IDX_FCLR, 16'h0000);
        wr(`TMR16_IDX_WAVE, 16'h0010);
        wr(`TMR16_IDX_OVR, 16'h0007);
        @(posedge mclk);
        chk("pad", 3'h1, waveform_output_pad);
        chk("clb", 3'h7, waveform_output_clb);
        chk("pad enable", 3'h1, waveform_output_pad_oe);
    endtask
    task automatic t_run;
        int c;
        for (int s = 0; s < 8; s++)
        begin
            wr(`TMR16_IDX_MAIN, s * 2 + 1);
            wu;
            wu;
            c = 0;
            do begin @(posedge mclk); c++; end while (!update_event && c < 8000);
            chk("update spacing", 4 * dv[s], c);
        end
        wr(`TMR16_IDX_ESET, 16'h000C);
        rd("reset ignored", `TMR16_IDX_PER, 16'h0003);
        wr(`TMR16_IDX_MAIN, 16'h0001);
        wr(`TMR16_IDX_PERBUF, 16'h0005);
        wu;
        rd("locked", `TMR16_IDX_FSET, 16'h0001);
        wr(`TMR16_IDX_ECLR, 16'h0002);
        wu;
        rd("unlocked", `TMR16_IDX_PER, 16'h0005);
        standby_sleep <= 1'h1;
        repeat (4) @(posedge mclk);
        c = 0;
        repeat (24) begin @(posedge mclk); c += update_event; end
        chk("halted", 0, c);
        wr(`TMR16_IDX_MAIN, 16'h0081);
        wu;
        standby_sleep <= 1'h0;
        wr(`TMR16_IDX_MAIN, 16'h000F);
        wr(`TMR16_IDX_WAVE, 16'h0018);
        rd("auto lock", `TMR16_IDX_ESET, 16'h0002);
        wr(`TMR16_IDX_CMP0BUF, 16'h0002);
        rd("lock freed", `TMR16_IDX_ESET, 16'h0000);
        wu;
        rd("relocked", `TMR16_IDX_ESET, 16'h0002);
        rd("compare copy", `TMR16_IDX_COMPARE_ZERO_VALUE, 16'h0002);
        wr(`TMR16_IDX_MAIN, 16'h0001);
        wr(`TMR16_IDX_WAVE, 16'h0016);
        wu;
        c = 0;
        do
        begin
            @(posedge mclk);
            c++;
        end
        while (!update_event && c < 8000);
        chk("dual spacing", 10, c);
    endtask
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'h0;
        t_regs;
        t_buf;
        t_run;
        conclude;
    end
    // Watchdog
    initial
    begin
        repeat (100000) @(posedge mclk);
        mismatches++;
        conclude;
    end
endmodule // test_tmr16_ctrl
